// *** logic/mpfe_pkg.sv ***
// Constants, state codes and carrier types of the memory programming front end.
package mpfe_pkg;
  // Serial instruction bytes.
  localparam logic [7:0] OP_AC = 8'hAC;
  localparam logic [7:0] SUB_UNLOCK = 8'h53;
  localparam logic [7:0] SUB_ERASE = 8'h80;
  localparam logic [7:0] SUB_W_LOW = 8'hA0;
  localparam logic [7:0] SUB_W_HIGH = 8'hA8;
  localparam logic [7:0] SUB_W_EXT = 8'hA4;
  localparam logic [7:0] SUB_W_LOCK = 8'hE0;
  localparam logic [7:0] SUB_EXT = 8'h08;
  localparam logic [7:0] OP_POLL = 8'hF0;
  localparam logic [7:0] OP_LD_EXT = 8'h4D;
  localparam logic [7:0] OP_LD_HI = 8'h48;
  localparam logic [7:0] OP_LD_LO = 8'h40;
  localparam logic [7:0] OP_LD_EE = 8'hC1;
  localparam logic [7:0] OP_RD_HI = 8'h28;
  localparam logic [7:0] OP_RD_LO = 8'h20;
  localparam logic [7:0] OP_WR_PAGE = 8'h4C;
  localparam logic [7:0] OP_WR_EE_PAGE = 8'hC2;
  localparam logic [7:0] OP_RD_FUSE = 8'h50;
  localparam logic [7:0] OP_RD_LOCK = 8'h58;
  // Test port instructions and registers.
  localparam int IR_W = 4;
  localparam logic [3:0] IR_RESET = 4'hC;
  localparam logic [3:0] IR_UNLOCK = 4'h4;
  localparam logic [3:0] IR_CMD = 4'h5;
  localparam logic [3:0] IR_STREAM = 4'h6;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam int UNLOCK_W = 16;
  localparam logic [15:0] UNLOCK_KEY = 16'hA370;
  localparam int CMD_W = 15;
  localparam int STREAM_BITS = 2048;
  // Register map, fields and reset values.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FUSE = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0C;
  localparam int TPD_BIT = 0;
  localparam int TPEN_BIT = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FUSE_LOW_RST = 8'hFF;
  localparam logic [7:0] FUSE_HIGH_RST = 8'hBF;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing.
  localparam int CLK_KHZ = 40000;
  localparam int TWD_FLASH_US = 2600;
  localparam int BUSY_CYC = TWD_FLASH_US * CLK_KHZ / 1000;
  localparam logic [1:0] RSTPIN_CLR_CYC = 2'h2;

  typedef enum logic [3:0] {
    TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SDRS = 4'h2, TAP_CDR = 4'h3,
    TAP_SDR = 4'h4, TAP_E1DR = 4'h5, TAP_PDR = 4'h6, TAP_E2DR = 4'h7,
    TAP_UDR = 4'h8, TAP_SIRS = 4'h9, TAP_CIR = 4'hA, TAP_SIR = 4'hB,
    TAP_E1IR = 4'hC, TAP_PIR = 4'hD, TAP_E2IR = 4'hE, TAP_UIR = 4'hF
  } mpfe_tap_e;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic rst_n;
    logic tck;
    logic tms;
    logic tdi;
  } mpfe_pins_s;
  localparam mpfe_pins_s PINS_RST = 6'h08;

  typedef struct packed {
    logic valid;
    logic [23:0] page_word;
  } mpfe_fl_commit_s;

  typedef struct packed {
    logic valid;
    logic [9:0] addr;
    logic [31:0] data;
    logic [3:0] mask;
  } mpfe_ee_commit_s;

  typedef struct packed {
    logic apply;
    logic exec;
    logic [14:0] cmd;
  } mpfe_tcmd_s;
endpackage

// *** logic/mpfe_top.sv ***
// Memory programming front end: serial and test port entry paths with AXI4-Lite registers.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Function
// - Third byte sent out echoes second byte received; all four bytes always shift.
// - Serial input sampled on rising clock edge, output changed on falling edge.
// - Opcode 0x48 loads page buffer word high byte at third-byte address.
// - Opcode 0x40 loads page buffer word low byte at third-byte address.
// - Opcode 0x4D loads the extended address byte from the third byte.
// - Opcode 0xC1 loads one EEPROM page buffer byte at low address bits.
// - Opcodes 0x28 and 0x20 return high and low program word bytes.
// - Opcode 0x4C commits program page buffer to the addressed page.
// - Opcode 0xC2 commits EEPROM page buffer to the addressed page.
// - Fuse decode: 50/08 reads extended, AC/A8 writes high, AC/A4 writes extended.
// - Poll returns busy in bit 0; programmer waits for it low.
// - Fuse and lock bits read zero when programmed, one when not.
// - Program memory addresses are word addresses, any word in the page.
// - Test port shift registers move least significant bit first.
// - Test port instruction register is four bits wide.
// - Test port needs enable fuse and clear disable bit; reset pin clears it.
// - Instruction 0xC selects unlatched one-bit reset register holding the core in reset.
// - Instruction 0x4 shifts 16-bit unlock register, compared with key at update.
// - Unlock key is 0xA370; unlock register clears at reset.
// - Instruction 0x5 captures previous result and shifts in a 15-bit command.
// - Command update applies it; each idle visit gives one execute pulse.
// - Instruction 0x6 streams bytes into page buffer during shift, none at update.
module mpfe_top #(
  parameter int PAGE_WORDS = 128,
  parameter int BUSY_CYCLES = mpfe_pkg::BUSY_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mpfe_pkg::mpfe_pins_s pins,
  output logic miso_o,
  output logic miso_oe,
  output logic tdo_o,
  output logic tdo_oe,
  output logic core_hold,
  output mpfe_pkg::mpfe_fl_commit_s fl_commit,
  output mpfe_pkg::mpfe_ee_commit_s ee_commit,
  input wire logic [6:0] pbuf_idx,
  output logic [15:0] pbuf_word,
  output logic [23:0] mem_rd_addr,
  input wire logic [15:0] mem_rd_data,
  output mpfe_pkg::mpfe_tcmd_s tcmd,
  input wire logic [14:0] tcmd_result
);
  import mpfe_pkg::*;

  localparam logic [19:0] BUSY_LOAD = 20'(BUSY_CYCLES);

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_FUSE) || (a == ADDR_CMD);
  endfunction

  function automatic mpfe_tap_e tap_next(input mpfe_tap_e s, input logic tms);
    case (s)
      TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
      TAP_RTI, TAP_UDR, TAP_UIR: tap_next = tms ? TAP_SDRS : TAP_RTI;
      TAP_SDRS: tap_next = tms ? TAP_SIRS : TAP_CDR;
      TAP_CDR, TAP_SDR: tap_next = tms ? TAP_E1DR : TAP_SDR;
      TAP_E1DR: tap_next = tms ? TAP_UDR : TAP_PDR;
      TAP_PDR: tap_next = tms ? TAP_E2DR : TAP_PDR;
      TAP_E2DR: tap_next = tms ? TAP_UDR : TAP_SDR;
      TAP_SIRS: tap_next = tms ? TAP_TLR : TAP_CIR;
      TAP_CIR, TAP_SIR: tap_next = tms ? TAP_E1IR : TAP_SIR;
      TAP_E1IR: tap_next = tms ? TAP_UIR : TAP_PIR;
      TAP_PIR: tap_next = tms ? TAP_E2IR : TAP_PIR;
      TAP_E2IR: tap_next = tms ? TAP_UIR : TAP_SIR;
      default: tap_next = TAP_TLR;
    endcase
  endfunction

  // Pins cross into aclk through two flops; the third stage only serves edge detection.
  mpfe_pins_s s1_r, s2_r, s3_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= PINS_RST;
      s2_r <= PINS_RST;
      s3_r <= PINS_RST;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire ser_act = !s2_r.rst_n;
  wire ser_rise = s2_r.sck && !s3_r.sck;
  wire ser_fall = !s2_r.sck && s3_r.sck;
  wire tck_rise = s2_r.tck && !s3_r.tck;
  wire tck_fall = !s2_r.tck && s3_r.tck;

  // Configuration state.
  logic [7:0] ctrl_r, fuse_low_r, fuse_high_r, fuse_ext_r, lock_r;
  logic [1:0] rcnt_r;
  logic [19:0] busy_cnt_r;
  wire busy = |busy_cnt_r;
  wire port_on = !fuse_high_r[TPEN_BIT] && !ctrl_r[TPD_BIT];

  // Serial instruction path.
  logic [4:0] bitcnt_r;
  logic [7:0] rx_r, tx_sh_r;
  logic [7:0] by_r [4];
  logic ld_res_r, exec_r, prog_en_r, miso_r;
  logic [7:0] ext_r;
  logic [23:0] rd_addr_r;
  wire [7:0] rx_new = {rx_r[6:0], s2_r.mosi};
  wire byte_done = ser_act && ser_rise && (bitcnt_r[2:0] == 3'h7);
  wire [1:0] byte_k = bitcnt_r[4:3];

  wire x_ac = exec_r && by_r[0] == OP_AC;
  wire x_unlock = x_ac && by_r[1] == SUB_UNLOCK;
  wire x_prog = exec_r && prog_en_r;
  wire x_erase = x_prog && x_ac && by_r[1] == SUB_ERASE;
  wire x_wlow = x_prog && x_ac && by_r[1] == SUB_W_LOW;
  wire x_whigh = x_prog && x_ac && by_r[1] == SUB_W_HIGH;
  wire x_wext = x_prog && x_ac && by_r[1] == SUB_W_EXT;
  wire x_wlock = x_prog && x_ac && by_r[1] == SUB_W_LOCK;
  wire x_ldext = x_prog && by_r[0] == OP_LD_EXT && by_r[1] == 8'h00 && by_r[3] == 8'h00;
  wire x_ldlo = x_prog && by_r[0] == OP_LD_LO;
  wire x_ldhi = x_prog && by_r[0] == OP_LD_HI;
  wire x_ldee = x_prog && by_r[0] == OP_LD_EE;
  wire x_wpage = x_prog && by_r[0] == OP_WR_PAGE;
  wire x_weep = x_prog && by_r[0] == OP_WR_EE_PAGE;
  wire fuse_wr = x_wlow || x_whigh || x_wext || x_wlock;
  wire busy_set = x_erase || fuse_wr || x_wpage || x_weep;
  wire known_w = x_unlock || busy_set || x_ldext || x_ldlo || x_ldhi || x_ldee;

  wire r_poll = by_r[0] == OP_POLL;
  wire r_hi = by_r[0] == OP_RD_HI;
  wire r_lo = by_r[0] == OP_RD_LO;
  wire r_flow = by_r[0] == OP_RD_FUSE && by_r[1] == 8'h00;
  wire r_fext = by_r[0] == OP_RD_FUSE && by_r[1] == SUB_EXT;
  wire r_lock = by_r[0] == OP_RD_LOCK && by_r[1] == 8'h00;
  wire r_fhigh = by_r[0] == OP_RD_LOCK && by_r[1] == SUB_EXT;
  // Fuse and lock values are returned raw, so a programmed bit reads zero.
  wire [7:0] res_w = !prog_en_r ? 8'h00 :
                     r_poll ? {7'h00, busy} :
                     r_hi ? mem_rd_data[15:8] :
                     r_lo ? mem_rd_data[7:0] :
                     r_flow ? fuse_low_r :
                     r_fext ? fuse_ext_r :
                     r_lock ? lock_r :
                     r_fhigh ? fuse_high_r : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn || !ser_act) begin
      bitcnt_r <= 5'h00;
      rx_r <= 8'h00;
      tx_sh_r <= 8'h00;
      miso_r <= 1'b0;
      ld_res_r <= 1'b0;
      exec_r <= 1'b0;
      prog_en_r <= 1'b0;
      rd_addr_r <= 24'h000000;
      for (int i = 0; i < 4; i++) begin
        by_r[i] <= 8'h00;
      end
    end else begin
      ld_res_r <= 1'b0;
      exec_r <= 1'b0;
      if (x_unlock) begin
        prog_en_r <= 1'b1;
      end
      if (ser_rise) begin
        rx_r <= rx_new;
        bitcnt_r <= bitcnt_r + 5'h01;
      end
      if (byte_done) begin
        by_r[byte_k] <= rx_new;
        tx_sh_r <= (byte_k == 2'h1) ? rx_new : 8'h00;
        ld_res_r <= (byte_k == 2'h2);
        exec_r <= (byte_k == 2'h3);
        if (byte_k == 2'h2) begin
          rd_addr_r <= {ext_r, by_r[1], rx_new};
        end
      end else if (ld_res_r) begin
        tx_sh_r <= res_w;
      end else if (ser_fall) begin
        miso_r <= tx_sh_r[7];
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end
  end
  assign miso_o = miso_r;
  assign miso_oe = ser_act;
  assign mem_rd_addr = rd_addr_r;

  // Test port path.
  mpfe_tap_e tap_r;
  logic [3:0] ir_r, ir_sh_r;
  logic [15:0] unlock_sh_r;
  logic [14:0] cmd_sh_r;
  logic [7:0] st_sh_r;
  logic [10:0] scnt_r;
  logic rst_dr_r, byp_r, jt_prog_en_r, tdo_r, tdo_oe_r;
  mpfe_tcmd_s tcmd_r;
  wire mpfe_tap_e tap_nx = tap_next(tap_r, s2_r.tms);
  wire in_sdr = tap_r == TAP_SDR;
  wire st_we = tck_rise && in_sdr && ir_r == IR_STREAM && jt_prog_en_r && scnt_r[2:0] == 3'h7;
  wire [7:0] st_byte_w = {s2_r.tdi, st_sh_r[7:1]};
  wire [6:0] st_word_w = scnt_r[10:4];
  wire st_hi_w = scnt_r[3];

  always_ff @(posedge aclk) begin
    if (!aresetn || !port_on) begin
      tap_r <= TAP_TLR;
      ir_r <= IR_CAPTURE;
      ir_sh_r <= 4'h0;
      unlock_sh_r <= 16'h0000;
      cmd_sh_r <= 15'h0000;
      st_sh_r <= 8'h00;
      scnt_r <= 11'h000;
      rst_dr_r <= 1'b0;
      byp_r <= 1'b0;
      jt_prog_en_r <= 1'b0;
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
      tcmd_r <= '0;
    end else begin
      tcmd_r.apply <= 1'b0;
      tcmd_r.exec <= 1'b0;
      if (tck_rise) begin
        tap_r <= tap_nx;
        case (tap_r)
          TAP_TLR: begin
            ir_r <= IR_CAPTURE;
            jt_prog_en_r <= 1'b0;
          end
          TAP_CIR: ir_sh_r <= IR_CAPTURE;
          TAP_SIR: ir_sh_r <= {s2_r.tdi, ir_sh_r[3:1]};
          TAP_UIR: ir_r <= ir_sh_r;
          TAP_CDR: begin
            cmd_sh_r <= tcmd_result;
            scnt_r <= 11'h000;
          end
          TAP_SDR: begin
            if (ir_r == IR_RESET) rst_dr_r <= s2_r.tdi;
            else if (ir_r == IR_UNLOCK) unlock_sh_r <= {s2_r.tdi, unlock_sh_r[15:1]};
            else if (ir_r == IR_CMD) cmd_sh_r <= {s2_r.tdi, cmd_sh_r[14:1]};
            else if (ir_r == IR_STREAM) begin
              st_sh_r <= st_byte_w;
              scnt_r <= scnt_r + 11'h001;
            end else byp_r <= s2_r.tdi;
          end
          TAP_UDR: begin
            if (ir_r == IR_UNLOCK) begin
              jt_prog_en_r <= (unlock_sh_r == UNLOCK_KEY);
            end
            if (ir_r == IR_CMD && jt_prog_en_r) begin
              tcmd_r.cmd <= cmd_sh_r;
              tcmd_r.apply <= 1'b1;
            end
          end
          default: begin
          end
        endcase
        if (tap_nx == TAP_RTI && tap_r != TAP_RTI && ir_r == IR_CMD && jt_prog_en_r) begin
          tcmd_r.exec <= 1'b1;
        end
      end
      if (tck_fall) begin
        tdo_oe_r <= (tap_r == TAP_SIR) || in_sdr;
        if (tap_r == TAP_SIR) tdo_r <= ir_sh_r[0];
        else if (ir_r == IR_RESET) tdo_r <= rst_dr_r;
        else if (ir_r == IR_UNLOCK) tdo_r <= unlock_sh_r[0];
        else if (ir_r == IR_CMD) tdo_r <= cmd_sh_r[0];
        else if (ir_r == IR_STREAM) tdo_r <= st_sh_r[0];
        else tdo_r <= byp_r;
      end
    end
  end
  assign tdo_o = tdo_r;
  assign tdo_oe = tdo_oe_r;
  assign tcmd = tcmd_r;
  // The reset bit is used straight from its shift stage, so the core reset follows each shift.
  assign core_hold = rst_dr_r && ir_r == IR_RESET;

  // Page buffers, fuses and pending timer.
  logic [15:0] pbuf_r [PAGE_WORDS];
  logic [7:0] ee_buf_r [4];
  logic [3:0] ee_mask_r;
  logic [15:0] pbuf_word_r;
  mpfe_fl_commit_s fl_commit_r;
  mpfe_ee_commit_s ee_commit_r;
  wire [6:0] ld_word = by_r[2][6:0];

  always_ff @(posedge aclk) begin
    pbuf_word_r <= pbuf_r[pbuf_idx];
    if (x_ldlo) begin
      pbuf_r[ld_word][7:0] <= by_r[3];
    end else if (x_ldhi) begin
      pbuf_r[ld_word][15:8] <= by_r[3];
    end else if (st_we) begin
      if (st_hi_w) pbuf_r[st_word_w][15:8] <= st_byte_w;
      else pbuf_r[st_word_w][7:0] <= st_byte_w;
    end
    if (x_ldee) begin
      ee_buf_r[by_r[2][1:0]] <= by_r[3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_r <= 8'h00;
      fuse_low_r <= FUSE_LOW_RST;
      fuse_high_r <= FUSE_HIGH_RST;
      fuse_ext_r <= FUSE_EXT_RST;
      lock_r <= LOCK_RST;
      busy_cnt_r <= 20'h00000;
      ee_mask_r <= 4'h0;
      fl_commit_r <= '0;
      ee_commit_r <= '0;
    end else begin
      fl_commit_r.valid <= 1'b0;
      ee_commit_r.valid <= 1'b0;
      if (x_ldext) ext_r <= by_r[2];
      if (x_wlow) fuse_low_r <= by_r[3];
      if (x_whigh) fuse_high_r <= by_r[3];
      if (x_wext) fuse_ext_r <= by_r[3];
      // Lock bits can only be programmed here; only aresetn restores them, as the erase instruction leaves lock_r alone.
      if (x_wlock) lock_r <= lock_r & by_r[3];
      if (busy_set) busy_cnt_r <= BUSY_LOAD;
      else if (busy) busy_cnt_r <= busy_cnt_r - 20'h00001;
      if (x_wpage) begin
        fl_commit_r.valid <= 1'b1;
        fl_commit_r.page_word <= {ext_r, by_r[1], by_r[2]};
      end
      if (x_weep) begin
        ee_commit_r.valid <= 1'b1;
        ee_commit_r.addr <= {by_r[1][1:0], by_r[2][7:2], 2'h0};
        ee_commit_r.data <= {ee_buf_r[3], ee_buf_r[2], ee_buf_r[1], ee_buf_r[0]};
        ee_commit_r.mask <= ee_mask_r;
        ee_mask_r <= 4'h0;
      end else if (x_ldee) begin
        ee_mask_r[by_r[2][1:0]] <= 1'b1;
      end
    end
  end
  assign pbuf_word = pbuf_word_r;
  assign fl_commit = fl_commit_r;
  assign ee_commit = ee_commit_r;

  // AXI4-Lite slave.
  logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  wire do_wr = aw_full_r && w_full_r && !bvalid_r;
  wire wr_ctrl = do_wr && awaddr_r == ADDR_CTRL && wstrb_r[0];
  wire [31:0] status_w = {26'h0000000, ser_act, core_hold, port_on, jt_prog_en_r, busy, prog_en_r};
  wire [31:0] rd_mux = (s_axi_araddr == ADDR_CTRL) ? {24'h000000, ctrl_r} :
                       (s_axi_araddr == ADDR_STATUS) ? status_w :
                       (s_axi_araddr == ADDR_FUSE) ? {lock_r, fuse_ext_r, fuse_high_r, fuse_low_r} :
                       (s_axi_araddr == ADDR_CMD) ? {17'h00000, tcmd_r.cmd} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      rcnt_r <= 2'h0;
    end else begin
      rcnt_r <= (ser_act && rcnt_r != RSTPIN_CLR_CYC) ? rcnt_r + 2'h1 : (ser_act ? rcnt_r : 2'h0);
      if (wr_ctrl) ctrl_r <= wdata_r[7:0];
      // A held reset pin wins over a software write in the same cycle.
      if (ser_act && rcnt_r == RSTPIN_CLR_CYC) ctrl_r[TPD_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= reg_hit(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (s_axi_arvalid && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready = !w_full_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  echo_byte_a: assert property (byte_done && byte_k == 2'h1 |=> tx_sh_r == by_r[1])
    else $error("Third serial byte does not echo the second.");
  miso_fall_a: assert property (ser_act && ser_fall && !ld_res_r && !byte_done
      |=> miso_r == $past(tx_sh_r[7]))
    else $error("Serial output did not move on the falling edge.");
  poll_result_a: assert property (ld_res_r && r_poll && prog_en_r
      |=> tx_sh_r == {7'h00, $past(busy)})
    else $error("Poll byte does not carry the pending flag.");
  page_commit_a: assert property (x_wpage |=> fl_commit_r.valid && busy
      && fl_commit_r.page_word == {$past(ext_r), $past(by_r[1]), $past(by_r[2])})
    else $error("Page commit missing or at the wrong address.");
  low_load_a: assert property (x_ldlo |=> pbuf_r[$past(ld_word)][7:0] == $past(by_r[3]))
    else $error("Low byte load did not reach the page buffer.");
  unlock_key_a: assert property (tck_rise && tap_r == TAP_UDR && ir_r == IR_UNLOCK && port_on
      |=> jt_prog_en_r == ($past(unlock_sh_r) == UNLOCK_KEY))
    else $error("Unlock result does not match key compare.");
  reset_hold_a: assert property (tck_rise && in_sdr && ir_r == IR_RESET && port_on
      |=> core_hold == $past(s2_r.tdi))
    else $error("Core reset does not follow the reset bit.");
  stream_byte_a: assert property (st_we |=> (($past(st_hi_w) ? pbuf_r[$past(st_word_w)][15:8]
      : pbuf_r[$past(st_word_w)][7:0]) == $past(st_byte_w)))
    else $error("Streamed byte not written to the page buffer.");
  port_off_a: assert property (!port_on |=> tap_r == TAP_TLR && !tdo_oe)
    else $error("Test port active while disabled.");
  unknown_op_a: assert property (exec_r && !known_w |=> fuse_high_r == $past(fuse_high_r)
      && busy_cnt_r <= $past(busy_cnt_r) && !fl_commit_r.valid)
    else $error("Unknown instruction changed state.");
endmodule

// *** tb/mpfe_prog_model.sv ***
// Behavioural serial programmer that drives the device pins.
`timescale 1ns/1ps
module mpfe_prog_model (
  input wire logic aclk,
  input wire logic miso,
  input wire logic tdo,
  output logic sck,
  output logic mosi,
  output logic rst_n,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    sck = 1'b0;
    mosi = 1'b1;
    rst_n = 1'b1;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic set_rst(input logic v);
    @(posedge aclk);
    rst_n <= v;
  endtask
  // All 32 bits always go out, whatever the echo shows.
  task automatic xfer(input logic [31:0] ins, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      @(posedge aclk);
      mosi <= ins[i];
      repeat (3) @(posedge aclk);
      sck <= 1'b1;
      repeat (4) @(posedge aclk);
      rx[i] = miso;
      sck <= 1'b0;
    end
    @(posedge aclk);
    mosi <= ~ins[0];
  endtask
  // The model is the only device on its chain, so page streaming would be allowed here.
  task automatic tap(input logic m, input logic d, output logic o);
    @(posedge aclk);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge aclk);
    tck <= 1'b1;
    repeat (4) @(posedge aclk);
    o = tdo;
    tck <= 1'b0;
  endtask
endmodule

// *** tb/memory_programming_front_end_tb.sv ***
// Self-checking bench for the memory programming front end.
`timescale 1ns/1ps
module memory_programming_front_end_tb;
  import mpfe_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, busy1;
  logic awready, wready, bvalid, arready, rvalid, miso, sck, mosi, rst_n;
  logic tck, tms, tdi, tdo, core_hold, miso_oe;
  logic [13:0] tdo_seq;
  localparam logic [13:0] TAP_TMS = 14'h2706;
  localparam logic [13:0] TAP_TDI = 14'h2180;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, res;
  logic [1:0] bresp, rresp;
  logic [6:0] pbuf_idx;
  logic [15:0] pbuf_word, mem_rd_data;
  logic [23:0] mem_rd_addr;
  mpfe_fl_commit_s fl_commit, fl_seen;
  mpfe_ee_commit_s ee_commit, ee_seen;
  int error_cnt = 0;
  int total_checks = 0;
  assign mem_rd_data = {mem_rd_addr[7:0] ^ 8'hA5, mem_rd_addr[7:0]};
  mpfe_top #(.BUSY_CYCLES(400)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pins({sck, mosi, rst_n, tck, tms, tdi}), .miso_o(miso), .miso_oe(miso_oe), .tdo_o(tdo),
    .tdo_oe(), .core_hold(core_hold), .fl_commit(fl_commit), .ee_commit(ee_commit),
    .pbuf_idx(pbuf_idx),
    .pbuf_word(pbuf_word), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .tcmd(), .tcmd_result(15'h0000));
  mpfe_prog_model prog (.aclk(aclk), .miso(miso), .tdo(tdo), .sck(sck), .mosi(mosi),
    .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (fl_commit.valid === 1'b1) fl_seen <= fl_commit;
    if (ee_commit.valid === 1'b1) ee_seen <= ee_commit;
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // For reads, d carries the expected data.
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic pr, sa, sw;
    logic [31:0] got;
    logic [1:0] gr;
    pr = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    for (int n = 0; n < 50 && pr; n++) begin
      @(negedge aclk);
      sa = wr ? awready : arready;
      sw = wready;
      got = rdata;
      gr = wr ? bresp : rresp;
      pr = !(wr ? bvalid : rvalid);
      @(posedge aclk);
      if (sa) awvalid <= 1'b0;
      if (sa) arvalid <= 1'b0;
      if (sw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (pr) begin
      error_cnt++;
      $display("[FAIL] %0t bus answer timed out", $time);
      report_and_stop;
    end
    chk(gr, er);
    if (!wr) chk(got, d);
  endtask
  // Each instruction is followed by busy polling, as the link demands.
  task automatic ser(input logic [31:0] ins);
    logic [31:0] p;
    prog.xfer(ins, res);
    prog.xfer(32'hF0000000, p);
    busy1 = p[0];
    for (int n = 0; n < 20 && p[0] !== 1'b0; n++) prog.xfer(32'hF0000000, p);
    if (p[0] !== 1'b0) begin
      error_cnt++;
      $display("[FAIL] %0t busy poll timed out", $time);
      report_and_stop;
    end
  endtask
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, pbuf_idx} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi(1'b0, ADDR_CTRL, {24'h000000, CTRL_RST}, RESP_OKAY);
    axi(1'b0, ADDR_FUSE, {LOCK_RST, FUSE_EXT_RST, FUSE_HIGH_RST, FUSE_LOW_RST},
        RESP_OKAY);
    axi(1'b1, ADDR_CTRL, 32'h00000001, RESP_OKAY);
    axi(1'b0, ADDR_CTRL, 32'h00000001, RESP_OKAY);
    axi(1'b1, 8'h10, 32'h00000000, RESP_SLVERR);
    prog.set_rst(1'b0);
    repeat (8) @(posedge aclk);
    axi(1'b0, ADDR_CTRL, 32'h00000000, RESP_OKAY);
    $display("register test done");
    ser(32'hAC530000);
    chk(res[15:8], 8'h53);
    chk(miso_oe, 1'b1);
    ser(32'h40000534);
    ser(32'h48000512);
    pbuf_idx <= 7'h05;
    repeat (3) @(posedge aclk);
    chk(pbuf_word, 16'h1234);
    ser(32'h4D000100);
    ser(32'h4C000500);
    chk(busy1, 1'b1);
    chk(fl_seen, {1'b1, 24'h010005});
    ser(32'hC1000177);
    ser(32'hC2000400);
    chk({ee_seen.valid, ee_seen.addr, ee_seen.mask, ee_seen.data[15:8]}, 23'h404277);
    ser(32'h28000500);
    chk(res[7:0], 8'hA0);
    ser(32'h20000500);
    chk(res[7:0], 8'h05);
    $display("page test done");
    ser(32'hACA8009F);
    ser(32'h58080000);
    chk(res[7:0], 8'h9F);
    ser(32'hACA400FE);
    ser(32'h50080000);
    chk(res[7:0], 8'hFE);
    ser(32'h12345678);
    chk(busy1, 1'b0);
    axi(1'b0, ADDR_FUSE, {LOCK_RST, 16'hFE9F, FUSE_LOW_RST}, RESP_OKAY);
    $display("fuse test done");
    // Walk to Shift-IR, load the reset instruction, then shift a one into its bit.
    for (int i = 0; i < 14; i++) begin
      prog.tap(TAP_TMS[i], TAP_TDI[i], tdo_seq[i]);
    end
    chk(tdo_seq[8:5], 4'h1);
    chk(core_hold, 1'b1);
    axi(1'b0, ADDR_STATUS, 32'h00000039, RESP_OKAY);
    $display("test port test done");
    report_and_stop;
  end
endmodule
